/* File: rtl/cpmcc_top.sv */
// power mode controller with the enable and setting port of the high-frequency clock generator
`timescale 1ns/10ps
`include "cpmcc_params.svh"

module cpmcc_top
  import cpmcc_pkg::*;
#(
  parameter logic [13:0] HW96_M = 14'h0001,
  parameter logic [4:0] HW96_N = 5'h01
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // core and wake-up sources
  input wire logic wait_exec,
  input wire logic wake_maskable,
  input wire logic wake_nmi,
  input wire logic wake_debug,
  input wire logic int_ack,
  input wire logic watchdog_reset,
  input wire logic debugger_reset,
  // clock status
  input wire logic hf_clock_stable_in,
  input wire logic lf_clock_stable_in,
  input wire logic multiplier_locked,
  // generator control
  output logic hf_generator_enable,
  output logic core_clock_enable,
  output logic host_clock_enable,
  output logic multiplier_output_gate,
  output logic [4:0] divider_value,
  output logic [13:0] multiplier_value,
  output logic [4:0] core_prescaler_value,
  output logic clock_monitor_start,
  output logic idle_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state, so writes always land before a following read
  logic phase_q;
  logic wr_q;
  logic [31:0] addr_q;
  wire logic take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else begin
      phase_q <= take;
      if (take) begin
        wr_q <= hwrite;
        addr_q <= haddr;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !take;
    end
  end
  wire logic wr_en = phase_q && wr_q;
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = wr_en && (a == r);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // wake-up latch
  logic nmi_q;
  logic dbg_q;
  logic wake_q;
  wire logic wake_set = wake_maskable || (wake_nmi && !nmi_q) || (wake_debug && !dbg_q);
  wire logic soft_rst = watchdog_reset || debugger_reset;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_q <= 1'b0;
      dbg_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      nmi_q <= wake_nmi;
      dbg_q <= wake_debug;
      if (wake_set)
        wake_q <= 1'b1;
      else if (int_ack || soft_rst)
        wake_q <= 1'b0;
    end
  end
  // a new detection, so a latched event left over does not keep clearing bits
  wire logic wake_det = wake_set && !wake_q;

  ////////////////////////////////////////////////////////////////////////////
  // status byte
  logic disable_q;
  logic idle_req_q;
  logic wbps_q;
  logic hf_ok_q;
  logic lf_ok_q;
  wire logic pmcs_wr = hit(addr_q, `CPMCC_PMCS_ADDR);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disable_q <= 1'b0;
      idle_req_q <= 1'b0;
      wbps_q <= 1'b0;
    end else if (soft_rst) begin
      disable_q <= 1'b0;
      idle_req_q <= 1'b0;
      wbps_q <= 1'b0;
    end else if (wake_det) begin
      disable_q <= 1'b0;
      idle_req_q <= 1'b0;
    end else if (pmcs_wr) begin
      disable_q <= hwdata[`CPMCC_BIT_DISABLE];
      idle_req_q <= hwdata[`CPMCC_BIT_IDLE];
      wbps_q <= hwdata[`CPMCC_BIT_WBPS];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hf_ok_q <= 1'b0;
      lf_ok_q <= 1'b0;
    end else begin
      hf_ok_q <= hf_clock_stable_in;
      lf_ok_q <= lf_clock_stable_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power mode sequencer
  cpmcc_mode_t mode_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= CPMCC_ACTIVE;
    end else if (soft_rst) begin
      mode_q <= CPMCC_ACTIVE;
    end else begin
      unique case (mode_q)
        CPMCC_ACTIVE: begin
          // wait-before bit is set by software ahead of the wait
          if (wait_exec && idle_req_q && wbps_q && lf_ok_q && !wake_set)
            mode_q <= CPMCC_IDLE;
        end
        CPMCC_IDLE: begin
          if (wake_set || wake_q)
            mode_q <= CPMCC_WAKE;
        end
        CPMCC_WAKE: begin
          if (hf_ok_q && !disable_q)
            mode_q <= CPMCC_ACTIVE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // generator settings
  logic [4:0] buf_n_q;
  logic [13:0] buf_m_q;
  logic [4:0] psc_reg_q;
  logic host_q;
  logic busy_q;
  wire logic ctrl_wr = hit(addr_q, `CPMCC_CTRL_ADDR);
  wire logic load1 = ctrl_wr && hwdata[`CPMCC_CTL_LOAD];
  wire logic load96 = ctrl_wr && hwdata[`CPMCC_CTL_LOAD96] && !hwdata[`CPMCC_CTL_LOAD];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_n_q <= `CPMCC_DEF_N;
      buf_m_q <= `CPMCC_DEF_M;
      psc_reg_q <= `CPMCC_PSC_RESET;
    end else if (hit(addr_q, `CPMCC_MULT_ADDR)) begin
      buf_n_q <= hwdata[`CPMCC_MULT_N_LSB +: 5];
      buf_m_q <= hwdata[`CPMCC_MULT_M_LSB +: 14];
    end else if (hit(addr_q, `CPMCC_PSC_ADDR)) begin
      psc_reg_q <= hwdata[4:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      divider_value <= `CPMCC_DEF_N;
      multiplier_value <= `CPMCC_DEF_M;
      core_prescaler_value <= `CPMCC_PSC_DIV1;
      host_q <= 1'b0;
      busy_q <= 1'b1;
      clock_monitor_start <= 1'b0;
    end else begin
      clock_monitor_start <= soft_rst && host_q;
      if (soft_rst && !host_q) begin
        divider_value <= `CPMCC_DEF_N;
        multiplier_value <= `CPMCC_DEF_M;
        core_prescaler_value <= `CPMCC_PSC_DIV1;
        busy_q <= 1'b1;
      end else if (load1) begin
        divider_value <= buf_n_q;
        multiplier_value <= buf_m_q;
        core_prescaler_value <= `CPMCC_PSC_DIV1;
        host_q <= 1'b0;
        busy_q <= 1'b1;
      end else if (load96) begin
        divider_value <= HW96_N;
        multiplier_value <= HW96_M;
        core_prescaler_value <= psc_reg_q;
        host_q <= 1'b1;
        busy_q <= 1'b1;
      end else if (multiplier_locked) begin
        busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables; the generator stops only once idle has really been entered
  wire logic gen_on = (mode_q != CPMCC_IDLE) || !disable_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hf_generator_enable <= 1'b1;
      core_clock_enable <= 1'b0;
      host_clock_enable <= 1'b0;
      multiplier_output_gate <= 1'b0;
      idle_mode <= 1'b0;
    end else begin
      hf_generator_enable <= gen_on || host_q;
      core_clock_enable <= (mode_q == CPMCC_ACTIVE) && !busy_q;
      host_clock_enable <= host_q && !busy_q;
      multiplier_output_gate <= !busy_q;
      idle_mode <= mode_q != CPMCC_ACTIVE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, reserved bits zero
  wire logic [7:0] pmcs_rd = {lf_ok_q, hf_ok_q, wbps_q, 2'b00, idle_req_q, disable_q, 1'b0};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (phase_q && !wr_q) begin
      unique case (addr_q)
        `CPMCC_PMCS_ADDR: hrdata <= {24'h00_0000, pmcs_rd};
        `CPMCC_MULT_ADDR: hrdata <= {10'h000, buf_m_q, 3'h0, buf_n_q};
        `CPMCC_PSC_ADDR: hrdata <= {27'h000_0000, psc_reg_q};
        `CPMCC_CTRL_ADDR: hrdata <= {27'h000_0000, idle_mode, busy_q, host_q, 2'b00};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_idle_gate_lf: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_q == CPMCC_ACTIVE && !lf_ok_q) |=> mode_q != CPMCC_IDLE) else $error("left active without lf clock");
  // soft resets force active mode, so checks that may meet one leave it out
  a_active_gate_hf: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_q == CPMCC_WAKE && !hf_ok_q && !soft_rst) |=> mode_q != CPMCC_ACTIVE) else $error("active without hf clock");
  a_wake_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_det |=> !disable_q && !idle_req_q) else $error("wake did not clear bits");
  a_wake_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    (wake_q && !int_ack && !soft_rst) |=> wake_q) else $error("wake latch dropped");
  a_gen_active: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == CPMCC_ACTIVE |=> hf_generator_enable) else $error("generator off in active");
  a_gen_idle_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_q == CPMCC_IDLE && disable_q && !host_q) |=> !hf_generator_enable) else $error("generator on in idle");
  a_idle_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_q == CPMCC_ACTIVE && wait_exec && idle_req_q && wbps_q && lf_ok_q && !wake_set && !soft_rst)
      |=> mode_q == CPMCC_IDLE ##1 idle_mode) else $error("idle not entered");
  a_load_div1: assert property (@(posedge hclk) disable iff (!hresetn)
    (load1 && !soft_rst) |=> core_prescaler_value == `CPMCC_PSC_DIV1 ##1 !multiplier_output_gate)
    else $error("method one pre-scaler wrong");
  a_gate_low: assert property (@(posedge hclk) disable iff (!hresetn)
    busy_q |=> !multiplier_output_gate) else $error("output not held low");
  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_q && !wr_q && addr_q == `CPMCC_PMCS_ADDR) |=> hrdata[4:3] == 2'b00 && !hrdata[0])
    else $error("reserved bits nonzero");
  a_core_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_q == CPMCC_ACTIVE && !busy_q) |=> core_clock_enable) else $error("core clock off in active");
  a_core_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q != CPMCC_ACTIVE |=> !core_clock_enable) else $error("core clock on outside active");
  a_busy_gates: assert property (@(posedge hclk) disable iff (!hresetn)
    busy_q |=> !core_clock_enable && !host_clock_enable) else $error("clock on while changing");
  a_wake_gen_on: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_q == CPMCC_WAKE |=> hf_generator_enable) else $error("generator off while waking");
  a_monitor_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (soft_rst && host_q) |=> clock_monitor_start) else $error("clock monitor not started");
  a_soft_defaults: assert property (@(posedge hclk) disable iff (!hresetn)
    (soft_rst && !host_q) |=> divider_value == `CPMCC_DEF_N && multiplier_value == `CPMCC_DEF_M && busy_q)
    else $error("defaults not restored");
  a_load96_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (load96 && !soft_rst) |=> divider_value == HW96_N && multiplier_value == HW96_M && host_q)
    else $error("method two settings wrong");
  a_status_soft: assert property (@(posedge hclk) disable iff (!hresetn)
    soft_rst |=> !disable_q && !idle_req_q && !wbps_q) else $error("status not cleared by soft reset");
  a_lf_status: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> lf_ok_q == $past(lf_clock_stable_in)) else $error("lf status does not follow input");
  a_hf_status: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> hf_ok_q == $past(hf_clock_stable_in)) else $error("hf status does not follow input");

  c_idle_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    mode_q == CPMCC_IDLE ##[1:50] mode_q == CPMCC_ACTIVE);
  c_load96: cover property (@(posedge hclk) disable iff (!hresetn) load96 ##[1:50] host_clock_enable);
  c_monitor: cover property (@(posedge hclk) disable iff (!hresetn) clock_monitor_start);
  c_idle_entry: cover property (@(posedge hclk) disable iff (!hresetn) mode_q == CPMCC_ACTIVE ##1 mode_q == CPMCC_IDLE);
  c_load1: cover property (@(posedge hclk) disable iff (!hresetn) load1 ##[1:50] core_clock_enable);

endmodule

/* File: rtl/cpmcc_params.svh */
// offsets, field positions, reset values and clock constants of the power mode block
`ifndef CPMCC_PARAMS_SVH
`define CPMCC_PARAMS_SVH
`define CPMCC_PMCS_ADDR 32'h0000_ff80
`define CPMCC_MULT_ADDR 32'h0000_ff84
`define CPMCC_PSC_ADDR 32'h0000_ff88
`define CPMCC_CTRL_ADDR 32'h0000_ff8c
`define CPMCC_PMCS_RESET 8'h00
`define CPMCC_BIT_DISABLE 1
`define CPMCC_BIT_IDLE 2
`define CPMCC_BIT_WBPS 5
`define CPMCC_BIT_HFOK 6
`define CPMCC_BIT_LFOK 7
`define CPMCC_CTL_LOAD 0
`define CPMCC_CTL_LOAD96 1
`define CPMCC_CTL_HOST 2
`define CPMCC_CTL_BUSY 3
`define CPMCC_CTL_IDLE 4
`define CPMCC_MULT_N_LSB 0
`define CPMCC_MULT_M_LSB 8
`define CPMCC_DEF_M 14'h03cf
`define CPMCC_DEF_N 5'h08
`define CPMCC_PSC_DIV1 5'h00
`define CPMCC_PSC_RESET 5'h00
`define CPMCC_REF_KHZ 32768
`define CPMCC_HOST_DIV 2
`endif

/* File: rtl/cpmcc_pkg.sv */
// types of the power mode and clock generator control block
package cpmcc_pkg;
  typedef enum logic [1:0] {
    CPMCC_ACTIVE,
    CPMCC_IDLE,
    CPMCC_WAKE
  } cpmcc_mode_t;
endpackage

/* File: bench/cpmcc_far_model.sv */
// far-side model: clock stability and multiplier lock sources of the power mode block
`timescale 1ns/10ps
module cpmcc_far_model #(
  parameter int HF_DLY = 10,
  parameter int LOCK_DLY = 20
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // generator state seen from the block, plus the bench's low-frequency clock status
  input wire logic hf_generator_enable,
  input wire logic [4:0] divider_value,
  input wire logic [13:0] multiplier_value,
  input wire logic lf_ok,
  // status back to the block
  output logic hf_clock_stable_in,
  output logic lf_clock_stable_in,
  output logic multiplier_locked
);
  int hf_cnt_q;
  int lock_cnt_q;
  logic [18:0] set_q;
  ////////////////////////////////////////////////////////////////////////////////
  // settles after a delay, drops at once when the generator stops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hf_cnt_q <= 0;
    else if (!hf_generator_enable)
      hf_cnt_q <= 0;
    else if (hf_cnt_q < HF_DLY)
      hf_cnt_q <= hf_cnt_q + 1;
  end
  // the output is held low until lock, so no usable clock reaches the controller before it
  assign hf_clock_stable_in = hf_generator_enable && (hf_cnt_q == HF_DLY) && multiplier_locked;
  ////////////////////////////////////////////////////////////////////////////////
  // a new setting loses lock at once, so a command never sees a stale lock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_cnt_q <= 0;
      set_q <= 19'h0_0000;
    end else if ({divider_value, multiplier_value} != set_q || !hf_generator_enable) begin
      lock_cnt_q <= 0;
      set_q <= {divider_value, multiplier_value};
    end else if (lock_cnt_q < LOCK_DLY) begin
      lock_cnt_q <= lock_cnt_q + 1;
    end
  end
  assign multiplier_locked = (lock_cnt_q == LOCK_DLY) && ({divider_value, multiplier_value} == set_q);
  assign lf_clock_stable_in = lf_ok;
endmodule

/* File: bench/core_power_mode_clock_control_bench.sv */
// register-level testbench of the power mode and clock generator control block
`timescale 1ns/10ps
`include "cpmcc_params.svh"
module core_power_mode_clock_control_bench;
  localparam logic [13:0] M96 = 14'h0123;
  localparam logic [4:0] N96 = 5'h0c;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rdata;
  logic [1:0] htrans = 2'b00;
  logic wait_exec = 0, wake_maskable = 0, wake_nmi = 0, wake_debug = 0, int_ack = 0;
  logic watchdog_reset = 0, debugger_reset = 0, lf_ok = 1, seen;
  logic hreadyout, hresp, hf_stable, lf_stable, locked, gen_en, core_en, host_en, gate, mon, idle;
  logic [31:0] hrdata;
  logic [4:0] div, psc;
  logic [13:0] mult;
  int num_errors = 0, tests_run = 0;
  always #50 hclk = ~hclk;
  cpmcc_top #(.HW96_M(M96), .HW96_N(N96)) cpmcc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wait_exec(wait_exec), .wake_maskable(wake_maskable),
    .wake_nmi(wake_nmi), .wake_debug(wake_debug), .int_ack(int_ack), .watchdog_reset(watchdog_reset),
    .debugger_reset(debugger_reset), .hf_clock_stable_in(hf_stable), .lf_clock_stable_in(lf_stable),
    .multiplier_locked(locked), .hf_generator_enable(gen_en), .core_clock_enable(core_en),
    .host_clock_enable(host_en), .multiplier_output_gate(gate), .divider_value(div),
    .multiplier_value(mult), .core_prescaler_value(psc), .clock_monitor_start(mon), .idle_mode(idle));
  cpmcc_far_model cpmcc_far_model_i (.hclk(hclk), .hresetn(hresetn), .hf_generator_enable(gen_en),
    .divider_value(div), .multiplier_value(mult), .lf_ok(lf_ok), .hf_clock_stable_in(hf_stable),
    .lf_clock_stable_in(lf_stable), .multiplier_locked(locked));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // address phase held until hready, then data phase held until hready again
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(name, exp, rdata);
  endtask
  task automatic wait_core();
    for (int i = 0; i < 200 && core_en !== 1'b1; i++) @(posedge hclk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd("status_reset", `CPMCC_PMCS_ADDR, 32'h0000_0080);
    chk("okay", 32'h0000_0000, {31'h0, hresp});
    chk("div_reset", 32'h0000_0008, {27'h0, div});
    chk("mult_reset", 32'h0000_03cf, {18'h0, mult});
    chk("host_reset", 32'h0000_0000, {31'h0, host_en});
    wait_core();
    rd("status_stable", `CPMCC_PMCS_ADDR, 32'h0000_00c0);
    xfer(`CPMCC_PMCS_ADDR, 1'b1, 32'hffff_ffff);
    rd("status_reserved", `CPMCC_PMCS_ADDR, 32'h0000_00e6);
    xfer(`CPMCC_PMCS_ADDR, 1'b1, 32'h0000_0000);
    rd("status_clear", `CPMCC_PMCS_ADDR, 32'h0000_00c0);
    rd("unmapped", 32'h0000_ffa0, 32'h0000_0000);
    $display("test registers done");
    // no idle entry while the low-frequency clock is unstable
    lf_ok <= 1'b0;
    // memory zone wait cycles belong to the bus unit; software would add them here
    xfer(`CPMCC_PMCS_ADDR, 1'b1, 32'h0000_0026);
    @(posedge hclk) wait_exec <= 1'b1;
    @(posedge hclk) wait_exec <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("idle_no_lf", 32'h0000_0000, {31'h0, idle});
    lf_ok <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("gen_active", 32'h0000_0001, {31'h0, gen_en});
    wait_exec <= 1'b1;
    @(posedge hclk) wait_exec <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("idle_entered", 32'h0000_0001, {31'h0, idle});
    chk("gen_off", 32'h0000_0000, {31'h0, gen_en});
    chk("core_gated", 32'h0000_0000, {31'h0, core_en});
    rd("status_idle", `CPMCC_PMCS_ADDR, 32'h0000_00a6);
    $display("test idle entry done");
    @(posedge hclk) wake_nmi <= 1'b1;
    @(posedge hclk) wake_nmi <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("gen_rewake", 32'h0000_0001, {31'h0, gen_en});
    chk("idle_hold", 32'h0000_0001, {31'h0, idle});
    wait_core();
    repeat (2) @(posedge hclk);
    chk("idle_left", 32'h0000_0000, {31'h0, idle});
    rd("status_wake", `CPMCC_PMCS_ADDR, 32'h0000_00e0);
    // software would keep memory zone zero slow for 0.5 s from here, outside this block
    @(posedge hclk) int_ack <= 1'b1;
    @(posedge hclk) int_ack <= 1'b0;
    $display("test wake done");
    xfer(`CPMCC_PSC_ADDR, 1'b1, 32'h0000_0003);
    xfer(`CPMCC_MULT_ADDR, 1'b1, 32'h0003_9206);
    xfer(`CPMCC_CTRL_ADDR, 1'b1, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk("gate_low", 32'h0000_0000, {31'h0, gate});
    chk("m1_set", 32'h0003_9206, {10'h0, mult, 3'h0, div});
    chk("m1_psc", 32'h0000_0000, {27'h0, psc});
    wait_core();
    xfer(`CPMCC_CTRL_ADDR, 1'b1, 32'h0000_0002);
    repeat (2) @(posedge hclk);
    chk("m2_set", {10'h0, M96, 3'h0, N96}, {10'h0, mult, 3'h0, div});
    chk("m2_psc", 32'h0000_0003, {27'h0, psc});
    wait_core();
    rd("host_on", `CPMCC_CTRL_ADDR, 32'h0000_0004);
    chk("host_en", 32'h0000_0001, {31'h0, host_en});
    chk("gate_on", 32'h0000_0001, {31'h0, gate});
    $display("test settings done");
    seen = 1'b0;
    @(posedge hclk) watchdog_reset <= 1'b1;
    @(posedge hclk) watchdog_reset <= 1'b0;
    repeat (4) @(posedge hclk) seen = seen | (mon === 1'b1);
    chk("monitor", 32'h0000_0001, {31'h0, seen});
    chk("kept", {27'h0, N96}, {27'h0, div});
    xfer(`CPMCC_CTRL_ADDR, 1'b1, 32'h0000_0001);
    wait_core();
    @(posedge hclk) debugger_reset <= 1'b1;
    @(posedge hclk) debugger_reset <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("defaults", 32'h0003_cf08, {10'h0, mult, 3'h0, div});
    rd("status_soft", `CPMCC_PMCS_ADDR, 32'h0000_0080);
    $display("test soft reset done");
    stop_test();
  end
endmodule
